// ### inc/ppdp_pkg.sv
// Purpose: shared constants and types of the port P pin data path
// Assumes: eight pins, 8-bit register port, byte addresses
// Notes:   owner codes follow a gray order gpio, sci, tim, pwm

package ppdp_pkg;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  localparam int PPDP_ADDR_W = 16;
  localparam int PPDP_DATA_W = 8;
  localparam int PPDP_PINS = 8;

  localparam logic [15:0] PPDP_ADDR_DATA = 16'h0258;
  localparam logic [15:0] PPDP_ADDR_INPUT = 16'h0259;
  localparam logic [15:0] PPDP_ADDR_DIR = 16'h025a;
  localparam logic [15:0] PPDP_ADDR_STAT = 16'h0260;
  localparam logic [15:0] PPDP_ADDR_MASK = 16'h0261;

  localparam logic [7:0] PPDP_RST_DATA = 8'h00;
  localparam logic [7:0] PPDP_RST_DIR = 8'h00;
  localparam logic [7:0] PPDP_RST_STAT = 8'h00;
  localparam logic [7:0] PPDP_RST_MASK = 8'h00;
  localparam logic [7:0] PPDP_RD_NONE = 8'h00;

  // ------------------------------------------------------------
  // pin roles
  // ------------------------------------------------------------
  localparam logic [2:0] PPDP_PIN_SHUTDOWN = 3'h7;
  localparam logic [2:0] PPDP_PIN_SCI_TX = 3'h2;
  localparam logic [2:0] PPDP_PIN_SCI_RX = 3'h0;
  localparam logic [2:0] PPDP_PIN_TIM_HI = 3'h2;
  localparam int PPDP_TIM_CH = 3;

  typedef enum logic [1:0] {
    PPDP_OWN_GPIO = 2'b00,
    PPDP_OWN_SCI = 2'b01,
    PPDP_OWN_TIM = 2'b11,
    PPDP_OWN_PWM = 2'b10
  } ppdp_owner_t;

  // alternate function requests from neighbouring modules
  typedef struct packed {
    logic [7:0] pwmEn;
    logic [7:0] pwmOut;
    logic pwmShutdownEn;
    logic [2:0] timOcEn;
    logic [2:0] timOut;
    logic sciTxEn;
    logic sciRxEn;
    logic sciTxd;
  } ppdp_alt_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } ppdp_drive_t;

  // fixed priority per pin: pwm, timer, serial, gpio
  function automatic ppdp_owner_t ppdp_owner(input logic [2:0] idx,
                                            input ppdp_alt_t alt);
    ppdp_owner_t own;
    own = PPDP_OWN_GPIO;
    if (alt.pwmEn[idx] ||
        (idx == PPDP_PIN_SHUTDOWN && alt.pwmShutdownEn)) begin
      own = PPDP_OWN_PWM;
    end else if (idx <= PPDP_PIN_TIM_HI && alt.timOcEn[idx[1:0]]) begin
      own = PPDP_OWN_TIM;
    end else if ((idx == PPDP_PIN_SCI_TX && alt.sciTxEn) ||
                 (idx == PPDP_PIN_SCI_RX && alt.sciRxEn)) begin
      own = PPDP_OWN_SCI;
    end
    return own;
  endfunction

endpackage

// ### core/ppdp_pin_mux.sv
// Purpose: per-pin owner resolution and drive selection
// Assumes: alternate requests are synchronous to clk_sys
// Notes:   purely combinational; the top registers the drive
`timescale 1ns/1ns

module ppdp_pin_mux
  import ppdp_pkg::*;
(
  input wire ppdp_alt_t alt,
  input wire logic [7:0] dataBits,
  input wire logic [7:0] dirBits,
  output ppdp_drive_t drive,
  output logic [15:0] ownerBits
);

  // ------------------------------------------------------------
  // drive select
  // ------------------------------------------------------------
  always_comb begin
    ppdp_owner_t own;
    own = PPDP_OWN_GPIO;
    drive = '0;
    ownerBits = '0;
    for (int i = 0; i < PPDP_PINS; i++) begin
      own = ppdp_owner(3'(i), alt);
      ownerBits[2*i +: 2] = own;
      unique case (own)
        PPDP_OWN_PWM: begin
          // shutdown turns pin 7 into the fault input, dir bit untouched
          if (3'(i) == PPDP_PIN_SHUTDOWN && alt.pwmShutdownEn) begin
            drive.oe[i] = 1'b0;
            drive.out[i] = 1'b0;
          end else begin
            drive.oe[i] = 1'b1;
            drive.out[i] = alt.pwmOut[i];
          end
        end
        PPDP_OWN_TIM: begin
          drive.oe[i] = 1'b1;
          drive.out[i] = alt.timOut[i % PPDP_TIM_CH];
        end
        PPDP_OWN_SCI: begin
          // transmit pin drives, receive pin listens
          drive.oe[i] = (3'(i) == PPDP_PIN_SCI_TX);
          drive.out[i] = (3'(i) == PPDP_PIN_SCI_TX) ? alt.sciTxd : 1'b0;
        end
        PPDP_OWN_GPIO: begin
          drive.oe[i] = dirBits[i];
          drive.out[i] = dataBits[i];
        end
      endcase
    end
  end

endmodule // ppdp_pin_mux

// ### core/ppdp_top.sv
// Purpose: port P pin data path with register port and pin mux
// Assumes: pin inputs synchronous to clk_sys; one register per byte
// Notes:   read data stand only in the cycle after the read strobe
//
// Functional notes
// - gpio output mode drives the stored data bit onto the pin.
// - data read gives stored bit if direction 1, else buffered pin.
// - pin 7 goes to modulator when its channel or shutdown is enabled.
// - pins 6 to 3 go to modulator when their channel is enabled.
// - pins 2 and 0: modulator, then timer, then serial, then gpio.
// - pin 1: modulator, then timer, then gpio; no serial use.
// - pin 2 carries serial transmit, pin 0 receive, pins 2-0 timers.
// - only pins driven for two cycles feed pin interrupts; input pins do not.
// - input register always returns buffered pin states.
// - writes to the input register change nothing.
// - reset clears all stored data bits to zero.
// - data register reads and writes are allowed at any time.
// - direction 1 means output, 0 input, unless a function forces it.
// - shutdown forces pin 7 to input, direction bit unchanged.
//
// Chosen here: strobed register access.
`timescale 1ns/1ns

module ppdp_top
  import ppdp_pkg::*;
#(
  parameter int PINS = PPDP_PINS
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic [PPDP_ADDR_W-1:0] regAddr,
  input wire logic [PPDP_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [PPDP_DATA_W-1:0] regRdData,
  // alternate function requests
  input wire ppdp_alt_t alt,
  // pins
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  // sampled pins toward neighbours, owner report and interrupt
  output logic [7:0] pinSample,
  output logic sciRxd,
  output logic [2:0] timIn,
  output logic pwmFault,
  output logic [15:0] pinOwner,
  output logic irq
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // pin roles are hard wired to an eight pin port
  if (PINS != PPDP_PINS) begin : g_bad_pins
    $error("ppdp_top serves exactly eight pins");
  end

  // one register bit per pin, so the data word must match the port
  if (PPDP_DATA_W != PINS) begin : g_bad_data_w
    $error("ppdp_top needs one register bit per pin");
  end

  if (PPDP_ADDR_W != $bits(PPDP_ADDR_DATA)) begin : g_bad_addr_w
    $error("ppdp_top needs the full register address width");
  end

  // only the lowest pins carry timer lines
  if (PPDP_TIM_CH != PPDP_PIN_TIM_HI + 1) begin : g_bad_tim_ch
    $error("ppdp_top routes one timer channel per low pin");
  end

  // owner order assumes the serial lines sit on timer pins
  if (PPDP_PIN_SCI_TX > PPDP_PIN_TIM_HI) begin : g_bad_sci_pin
    $error("serial transmit pin lies outside the timer pins");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // exact match; a partial decode would alias the neighbour ports
  function automatic logic addr_hit(input logic [PPDP_ADDR_W-1:0] addr,
                                    input logic [15:0] target);
    return (addr == target);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] data_q, data_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] rdData_q, rdData_d;
  logic [7:0] pinSync_q, pinSync_d;
  logic [7:0] pinOut_q, pinOut_d;
  logic [7:0] pinOe_q, pinOe_d;
  logic [7:0] drvDly_q, drvDly_d;
  logic [7:0] oeDly_q, oeDly_d;
  logic [15:0] owner_q, owner_d;

  ppdp_drive_t drive;
  logic [15:0] ownerBits;
  logic [7:0] dataView;
  logic [7:0] mismatch;
  logic hitData, hitInput, hitDir, hitStat, hitMask;
  logic wrData, wrDir, wrMask, rdStat;
  logic [7:0] pend;

  // ------------------------------------------------------------
  // pin mux
  // ------------------------------------------------------------
  ppdp_pin_mux u_mux (
    .alt(alt),
    .dataBits(data_q),
    .dirBits(dir_q),
    .drive(drive),
    .ownerBits(ownerBits)
  );

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  always_comb begin
    hitData = addr_hit(regAddr, PPDP_ADDR_DATA);
    hitInput = addr_hit(regAddr, PPDP_ADDR_INPUT);
    hitDir = addr_hit(regAddr, PPDP_ADDR_DIR);
    hitStat = addr_hit(regAddr, PPDP_ADDR_STAT);
    hitMask = addr_hit(regAddr, PPDP_ADDR_MASK);
    // only three addresses take writes; input and status ignore them
    wrData = regWr && hitData;
    wrDir = regWr && hitDir;
    wrMask = regWr && hitMask;
    // a status read is also its clear
    rdStat = regRd && hitStat;
  end

  // per bit read source follows the stored direction only
  always_comb begin
    dataView = (dir_q & data_q) | (~dir_q & pinSync_q);
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_comb begin
    data_d = data_q;
    dir_d = dir_q;
    mask_d = mask_q;
    if (wrData) begin
      data_d = regWrData;
    end
    if (wrDir) begin
      dir_d = regWrData;
    end
    if (wrMask) begin
      mask_d = regWrData;
    end
    // input and status addresses take no write
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= PPDP_RST_DATA;
      dir_q <= PPDP_RST_DIR;
      mask_q <= PPDP_RST_MASK;
    end else begin
      data_q <= data_d;
      dir_q <= dir_d;
      mask_q <= mask_d;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    rdData_d = PPDP_RD_NONE;
    if (regRd) begin
      unique case (1'b1)
        hitData: rdData_d = dataView;
        hitInput: rdData_d = pinSync_q;
        hitDir: rdData_d = dir_q;
        hitStat: rdData_d = stat_q;
        hitMask: rdData_d = mask_q;
        default: rdData_d = PPDP_RD_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= PPDP_RD_NONE;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // ------------------------------------------------------------
  // pin sample
  // ------------------------------------------------------------
  // pins sampled regardless of direction, so driven pins read back
  always_comb begin
    pinSync_d = pinIn;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pinSync_q <= 8'h00;
    end else begin
      pinSync_q <= pinSync_d;
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  // delayed copies let the overload check skip fresh drive edges
  always_comb begin
    pinOut_d = drive.out;
    pinOe_d = drive.oe;
    drvDly_d = pinOut_q;
    oeDly_d = pinOe_q;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pinOut_q <= 8'h00;
      pinOe_q <= 8'h00;
      drvDly_q <= 8'h00;
      oeDly_q <= 8'h00;
    end else begin
      pinOut_q <= pinOut_d;
      pinOe_q <= pinOe_d;
      drvDly_q <= drvDly_d;
      oeDly_q <= oeDly_d;
    end
  end

  // ------------------------------------------------------------
  // owner report
  // ------------------------------------------------------------
  // registered beside the drive so both describe the same cycle
  always_comb begin
    owner_d = ownerBits;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      owner_q <= 16'h0000;
    end else begin
      owner_q <= owner_d;
    end
  end

  // ------------------------------------------------------------
  // overload status and interrupt
  // ------------------------------------------------------------
  // the sample lags the drive by one edge, so compare against the
  // drive of the cycle before and only while it held two cycles
  always_comb begin
    mismatch = pinOe_q & oeDly_q & ~(pinOut_q ^ drvDly_q) &
               (pinSync_q ^ drvDly_q);
  end

  // a read clears the status, but a new event in that cycle wins
  always_comb begin
    stat_d = stat_q;
    if (rdStat) begin
      stat_d = 8'h00;
    end
    stat_d = stat_d | mismatch;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= PPDP_RST_STAT;
    end else begin
      stat_q <= stat_d;
    end
  end

  // unmasked events only; the sticky bits stay readable either way
  always_comb begin
    pend = stat_q & mask_q;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    regRdData = rdData_q;
    pinOut = pinOut_q;
    pinOe = pinOe_q;
    pinSample = pinSync_q;
    sciRxd = pinSync_q[PPDP_PIN_SCI_RX];
    timIn = pinSync_q[PPDP_PIN_TIM_HI:0];
    pwmFault = pinSync_q[PPDP_PIN_SHUTDOWN];
    pinOwner = owner_q;
    irq = |pend;
  end

endmodule // ppdp_top

// ### test/ppdp_board_model.sv
// Purpose: board signals seen on the eight port pins
// Assumes: the board may overdrive a pin the port drives
// Notes:   no pull devices, so an undriven pin wanders
`timescale 1ns/1ns

module ppdp_board_model (
  input wire logic clk_sys,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] boardEn,
  input wire logic [7:0] boardVal,
  output logic [7:0] pinIn
);
  logic [7:0] floatLvl_q = 8'h00;

  // ------
  // pin level
  // ------
  // released pins flip every cycle so a stale value never looks right
  always_ff @(posedge clk_sys) begin
    floatLvl_q <= ~pinIn;
  end

  // board wins a contention, as a hard short would
  assign pinIn = (boardEn & boardVal) | (~boardEn & pinOe & pinOut) |
                 (~boardEn & ~pinOe & floatLvl_q);
endmodule // ppdp_board_model

// ### test/ppdp_top_properties.sv
// Purpose: port-level properties of the pin data path
// Assumes: drive and owner outputs trail their cause by one edge
// Notes:   bound from the bench top file
`timescale 1ns/1ns

module ppdp_top_properties
  import ppdp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [PPDP_ADDR_W-1:0] regAddr,
  input wire logic regRd,
  input wire logic [PPDP_DATA_W-1:0] regRdData,
  input wire ppdp_alt_t alt,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pinSample,
  input wire logic sciRxd,
  input wire logic [2:0] timIn,
  input wire logic pwmFault,
  input wire logic [15:0] pinOwner
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ------
  // properties
  // ------
  sequence s_in_rd;
    regRd && regAddr == PPDP_ADDR_INPUT;
  endsequence
  sequence s_run;
    $past(reset_n);
  endsequence

  a_rd_idle: assert property (
    !regRd |=> regRdData == PPDP_RD_NONE)
    else $error("read data outside its slot");
  a_in_read: assert property (
    s_in_rd |=> regRdData == $past(pinSample))
    else $error("input read not the sampled pins");
  a_pin_sample: assert property (
    s_run |-> pinSample == $past(pinIn))
    else $error("pin sample not one edge late");
  a_tap_lines: assert property (sciRxd == pinSample[0] &&
    timIn == pinSample[2:0] && pwmFault == pinSample[7])
    else $error("neighbour taps differ from sample");
  a_pwm_own: assert property (
    $past(reset_n) && $past(alt.pwmEn[6]) |->
    pinOwner[13:12] == PPDP_OWN_PWM && pinOe[6] &&
    pinOut[6] == $past(alt.pwmOut[6]))
    else $error("pin 6 not given to modulator");
  a_pin7_pwm: assert property (
    $past(reset_n) && ($past(alt.pwmEn[7]) || $past(alt.pwmShutdownEn)) |->
    pinOwner[15:14] == PPDP_OWN_PWM)
    else $error("pin 7 not given to modulator");
  a_shutdown_in: assert property (
    $past(reset_n) && $past(alt.pwmShutdownEn) |-> !pinOe[7])
    else $error("pin 7 driven under shutdown");
  a_tim_pin1: assert property (
    $past(reset_n) && $past(alt.timOcEn[1]) && !$past(alt.pwmEn[1]) |->
    pinOwner[3:2] == PPDP_OWN_TIM && pinOe[1] &&
    pinOut[1] == $past(alt.timOut[1]))
    else $error("pin 1 not given to timer");
  a_sci_tx: assert property (
    $past(reset_n) && $past(alt.sciTxEn) && !$past(alt.pwmEn[2]) &&
    !$past(alt.timOcEn[2]) |-> pinOwner[5:4] == PPDP_OWN_SCI &&
    pinOe[2] && pinOut[2] == $past(alt.sciTxd))
    else $error("pin 2 not carrying serial transmit");
  a_sci_rx: assert property (
    $past(reset_n) && $past(alt.sciRxEn) && !$past(alt.pwmEn[0]) &&
    !$past(alt.timOcEn[0]) |->
    pinOwner[1:0] == PPDP_OWN_SCI && !pinOe[0])
    else $error("pin 0 not a serial receive input");
  a_pin1_noser: assert property (pinOwner[3:2] != PPDP_OWN_SCI)
    else $error("pin 1 owned by serial");
endmodule // ppdp_top_properties

// ### test/ppdp_tb.sv
// Purpose: self-checking bench of the pin data path
// Assumes: drive settles one edge after its cause
// Notes:   the board model shorts pins on request
`timescale 1ns/1ns

module ppdp_tb
  import ppdp_pkg::*;
();
  logic clk_sys, reset_n, regWr, regRd, irq, sciRxd, pwmFault;
  logic [15:0] regAddr, pinOwner;
  logic [7:0] regWrData, regRdData, pinIn, pinOut, pinOe, pinSample;
  logic [7:0] boardEn, boardVal, dataM, dirM, v;
  logic [2:0] timIn;
  ppdp_alt_t alt;
  int fails, checks, seed;

  ppdp_top ppdp_top_inst (.clk_sys, .reset_n, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .alt, .pinIn, .pinOut, .pinOe, .pinSample, .sciRxd,
    .timIn, .pwmFault, .pinOwner, .irq);
  ppdp_board_model ppdp_board_model_inst (.clk_sys, .pinOut, .pinOe,
    .boardEn, .boardVal, .pinIn);

  // ------
  // model and bus tasks
  // ------
  // priority applied lowest first so higher owners overwrite
  function automatic logic [15:0] exp_drive(input ppdp_alt_t a,
      input logic [7:0] d, input logic [7:0] r);
    logic [7:0] o;
    logic [7:0] en;
    o = d;
    en = r;
    if (a.sciTxEn) begin
      o[2] = a.sciTxd;
      en[2] = 1'b1;
    end
    if (a.sciRxEn) en[0] = 1'b0;
    o[2:0] = (o[2:0] & ~a.timOcEn) | (a.timOut & a.timOcEn);
    en[2:0] = en[2:0] | a.timOcEn;
    o = (o & ~a.pwmEn) | (a.pwmOut & a.pwmEn);
    en = en | a.pwmEn;
    if (a.pwmShutdownEn) en[7] = 1'b0;
    return {o & en, en};
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 v = regRdData;
    chk(16'(v), 16'(x));
  endtask

  // read whose value is not predicted, used to clear sticky status
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------
  // stimulus
  // ------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  initial begin
    seed = 32'hd65b;
    reset_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    alt = '0;
    boardEn = 8'hff;
    boardVal = 8'h00;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc(PPDP_ADDR_DIR, PPDP_RST_DIR);
    rdc(PPDP_ADDR_MASK, PPDP_RST_MASK);
    rdc(16'h0300, PPDP_RD_NONE);
    wr(PPDP_ADDR_DIR, 8'hff);
    rdc(PPDP_ADDR_DATA, PPDP_RST_DATA);
    for (int i = 0; i < 40; i++) begin
      dataM = 8'($random(seed));
      dirM = 8'($random(seed));
      wr(PPDP_ADDR_DATA, dataM);
      wr(PPDP_ADDR_DIR, dirM);
      @(posedge clk_sys);
      alt <= ppdp_alt_t'(25'($random(seed)));
      boardEn <= ~dirM;
      boardVal <= 8'($random(seed));
      repeat (2) @(posedge clk_sys);
      #1 chk({pinOut & pinOe, pinOe}, exp_drive(alt, dataM, dirM));
      rdc(PPDP_ADDR_DATA, (dirM & dataM) | (~dirM & boardVal));
    end
    @(posedge clk_sys);
    alt <= '0;
    boardEn <= 8'h00;
    wr(PPDP_ADDR_DIR, 8'hff);
    wr(PPDP_ADDR_DATA, 8'h5a);
    wr(PPDP_ADDR_INPUT, 8'hff);
    rdc(PPDP_ADDR_DATA, 8'h5a);
    rdc(PPDP_ADDR_DIR, 8'hff);
    // random phase leaves unknown overload bits; clear, then expect none
    rd(PPDP_ADDR_STAT);
    rdc(PPDP_ADDR_STAT, 8'h00);
    // shorting pins 7 and 0 against their driven level
    @(posedge clk_sys);
    boardEn <= 8'h81;
    boardVal <= 8'ha5;
    repeat (4) @(posedge clk_sys);
    rdc(PPDP_ADDR_INPUT, 8'hdb);
    chk(16'(irq), 16'h0000);
    wr(PPDP_ADDR_MASK, 8'h01);
    @(posedge clk_sys);
    #1 chk(16'(irq), 16'h0001);
    @(posedge clk_sys);
    boardEn <= 8'h00;
    repeat (3) @(posedge clk_sys);
    rdc(PPDP_ADDR_STAT, 8'h81);
    rdc(PPDP_ADDR_STAT, 8'h00);
    @(posedge clk_sys);
    #1 chk(16'(irq), 16'h0000);
    stop_test();
  end
endmodule // ppdp_tb

bind ppdp_top ppdp_top_properties ppdp_top_properties_inst (.clk_sys,
  .reset_n, .regAddr, .regRd, .regRdData, .alt, .pinIn, .pinOut, .pinOe,
  .pinSample, .sciRxd, .timIn, .pwmFault, .pinOwner);
